// ==== rtl/pmp_ctrl_defs.svh ====
// Offsets, field positions and reset values of the parallel port control block.
`ifndef PMP_CTRL_DEFS_SVH
`define PMP_CTRL_DEFS_SVH
`define CTRL_ADDR        4'h0
`define STATUS_ADDR      4'h1
`define CTRL_RESET       16'h0000
`define CTRL_WMASK       16'hBFFF
`define BIT_PORT_EN      15
`define BIT_STOP_IDLE    13
`define BIT_MUX_HI       12
`define BIT_MUX_LO       11
`define BIT_BE_EN        10
`define BIT_WR_EN        9
`define BIT_RD_EN        8
`define BIT_CSF_HI       7
`define BIT_CSF_LO       6
`define BIT_ALP          5
`define BIT_SECOND_SELECT_POLARITY         4
`define BIT_CS1P         3
`define BIT_BEP          2
`define BIT_WRSP         1
`define BIT_RDSP         0
`endif

// ==== rtl/pmp_ctrl_pkg.sv ====
// Types shared by the parallel port control block.
package pmp_ctrl_pkg;
    typedef enum logic [1:0] {
        MUX_SEPARATE = 2'b00,
        MUX_LOW_BYTE = 2'b01,
        MUX_FULL     = 2'b10,
        MUX_RESERVED = 2'b11
    } mux_mode_t;
    typedef enum logic [1:0] {
        CSF_ADDR_BOTH = 2'b00,
        CSF_CS2_ONLY  = 2'b01,
        CSF_CS_BOTH   = 2'b10,
        CSF_RESERVED  = 2'b11
    } cs_func_t;
endpackage

// ==== rtl/pin_polarity.sv ====
// Applies a polarity bit to an active strobe, unless the pin is an address line.
`timescale 1ns/1ps
module pin_polarity (
    input  wire logic strobe_active,
    input  wire logic active_high,
    input  wire logic as_address,
    input  wire logic addr_bit,
    output logic      pin_level
);
    // Address lines carry the address bit and ignore polarity.
    always_comb begin
        if (as_address) begin
            pin_level = addr_bit;
        end else begin
            pin_level = active_high ? strobe_active : ~strobe_active;
        end
    end
endmodule

// ==== rtl/parallel_master_port_control.sv ====
// Control register and pin configuration of the parallel master port.
`timescale 1ns/1ps
`include "pmp_ctrl_defs.svh"
module parallel_master_port_control
    import pmp_ctrl_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        idle_mode,
    input  wire logic        xfer_cs1,
    input  wire logic        xfer_cs2,
    input  wire logic        xfer_latch_low,
    input  wire logic        xfer_latch_high,
    input  wire logic        xfer_wr,
    input  wire logic        xfer_rd,
    input  wire logic        xfer_be,
    input  wire logic        xfer_req,
    input  wire logic [15:0] xfer_addr,
    output logic             port_active,
    output logic             xfer_grant,
    output logic [1:0]       addr_data_mux_select,
    output logic             upper_addr_pins_en,
    output logic             chip_select_one,
    output logic             chip_select_two,
    output logic             addr_latch_low,
    output logic             addr_latch_high,
    output logic             write_strobe_out,
    output logic             write_strobe_oe,
    output logic             read_strobe_out,
    output logic             read_strobe_oe,
    output logic             byte_enable_out,
    output logic             byte_enable_oe
);
    // Control word, registered read data and the decoded pin roles.
    logic [15:0] ctrl_ff;
    logic [15:0] nxt_ctrl;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic        run;
    logic        cs1_is_addr;
    logic        cs2_is_addr;
    logic        g;
    logic        cs1_lvl;
    logic        cs2_lvl;
    logic        all_lvl;
    logic        alh_lvl;
    cs_func_t    chip_select_function;

    // Writable fields update on a write strobe; bit 14 stays zero.
    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_rdata = 16'h0000;
        if (reg_wr && reg_addr == `CTRL_ADDR) begin
            nxt_ctrl = reg_wdata & `CTRL_WMASK;
        end
        if (reg_rd) begin
            case (reg_addr)
                `CTRL_ADDR:   nxt_rdata = ctrl_ff;
                `STATUS_ADDR: nxt_rdata = {15'h0000, run};
                default:      nxt_rdata = 16'h0000;
            endcase
        end
    end

    // Registers only; read data stands the cycle after the read strobe.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_ff  <= `CTRL_RESET;
            rdata_ff <= 16'h0000;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = rdata_ff;

    // The port runs only when enabled and not stopped by idle.
    assign run = ctrl_ff[`BIT_PORT_EN]
               & ~(ctrl_ff[`BIT_STOP_IDLE] & idle_mode);
    assign port_active = run;
    assign xfer_grant  = run & xfer_req; // No access is granted while halted.
    assign g = run;

    // Mux layout; reserved code is left to software to avoid.
    assign addr_data_mux_select = ctrl_ff[`BIT_MUX_HI:`BIT_MUX_LO];
    assign upper_addr_pins_en = (ctrl_ff[`BIT_MUX_HI:`BIT_MUX_LO] != MUX_FULL);

    // Chip-select function decides which pins are address lines.
    assign chip_select_function = cs_func_t'(ctrl_ff[`BIT_CSF_HI:`BIT_CSF_LO]);
    assign cs1_is_addr = (chip_select_function != CSF_CS_BOTH);
    assign cs2_is_addr = (chip_select_function == CSF_ADDR_BOTH);

    // Gating by run keeps strobes inactive while disabled.
    pin_polarity u_cs1 (
        .strobe_active (g & xfer_cs1),
        .active_high   (ctrl_ff[`BIT_CS1P]),
        .as_address    (cs1_is_addr),
        .addr_bit      (chip_select_function == CSF_ADDR_BOTH ? xfer_addr[15] : xfer_addr[14]),
        .pin_level     (cs1_lvl)
    );
    pin_polarity u_cs2 (
        .strobe_active (g & xfer_cs2),
        .active_high   (ctrl_ff[`BIT_SECOND_SELECT_POLARITY]),
        .as_address    (cs2_is_addr),
        .addr_bit      (xfer_addr[14]),
        .pin_level     (cs2_lvl)
    );
    pin_polarity u_all (
        .strobe_active (g & xfer_latch_low),
        .active_high   (ctrl_ff[`BIT_ALP]),
        .as_address    (1'b0),
        .addr_bit      (1'b0),
        .pin_level     (all_lvl)
    );
    pin_polarity u_alh (
        .strobe_active (g & xfer_latch_high),
        .active_high   (ctrl_ff[`BIT_ALP]),
        .as_address    (1'b0),
        .addr_bit      (1'b0),
        .pin_level     (alh_lvl)
    );
    // Pin levels reach the ports unchanged.
    assign chip_select_one = cs1_lvl;
    assign chip_select_two = cs2_lvl;
    assign addr_latch_low  = all_lvl;
    assign addr_latch_high = alh_lvl;

    // Strobe pins drive only when their enable bit is set.
    assign write_strobe_oe  = ctrl_ff[`BIT_WR_EN];
    assign read_strobe_oe   = ctrl_ff[`BIT_RD_EN];
    assign byte_enable_oe   = ctrl_ff[`BIT_BE_EN];
    assign write_strobe_out = (g & xfer_wr) ~^ ctrl_ff[`BIT_WRSP];
    assign read_strobe_out  = (g & xfer_rd) ~^ ctrl_ff[`BIT_RDSP];
    assign byte_enable_out  = (g & xfer_be) ~^ ctrl_ff[`BIT_BEP];

    // Checks on what the block drives; the stimulus itself is never watched.
    a_disabled_quiet: assert property (@(posedge clock) disable iff (!arst_n)
        !ctrl_ff[`BIT_PORT_EN] |-> !xfer_grant) else $error("grant while disabled");
    a_idle_stop: assert property (@(posedge clock) disable iff (!arst_n)
        ctrl_ff[`BIT_STOP_IDLE] && idle_mode |-> !port_active) else $error("runs in idle");
    a_idle_run: assert property (@(posedge clock) disable iff (!arst_n)
        ctrl_ff[`BIT_PORT_EN] && !ctrl_ff[`BIT_STOP_IDLE] |-> port_active)
        else $error("stopped without cause");
    // Status reads report the running state of the cycle in which they were taken.
    a_status_read: assert property (@(posedge clock) disable iff (!arst_n)
        reg_rd && reg_addr == `STATUS_ADDR |=> reg_rdata == {15'h0000, $past(port_active)})
        else $error("status read wrong");
    // Layout and pin enables follow the control word.
    a_mux_upper: assert property (@(posedge clock) disable iff (!arst_n)
        addr_data_mux_select == 2'b10 |-> !upper_addr_pins_en) else $error("upper pins on");
    a_mux_split: assert property (@(posedge clock) disable iff (!arst_n)
        !addr_data_mux_select[1] |-> upper_addr_pins_en) else $error("upper pins off");
    a_write_enable: assert property (@(posedge clock) disable iff (!arst_n)
        reg_wr && reg_addr == `CTRL_ADDR |=> write_strobe_oe == $past(reg_wdata[`BIT_WR_EN]))
        else $error("write pin enable wrong");
    a_read_enable: assert property (@(posedge clock) disable iff (!arst_n)
        reg_wr && reg_addr == `CTRL_ADDR |=> read_strobe_oe == $past(reg_wdata[`BIT_RD_EN]))
        else $error("read pin enable wrong");
    a_be_enable: assert property (@(posedge clock) disable iff (!arst_n)
        reg_wr && reg_addr == `CTRL_ADDR |=> byte_enable_oe == $past(reg_wdata[`BIT_BE_EN]))
        else $error("byte pin enable wrong");
    // Select and latch pins: address lines ignore polarity, selects and latches honour it.
    a_cs_addr: assert property (@(posedge clock) disable iff (!arst_n)
        chip_select_function == CSF_ADDR_BOTH |-> chip_select_two == xfer_addr[14]
        && chip_select_one == xfer_addr[15]) else $error("address pin wrong");
    a_cs_single: assert property (@(posedge clock) disable iff (!arst_n)
        chip_select_function == CSF_CS2_ONLY |-> chip_select_one == xfer_addr[14])
        else $error("select one not on address");
    a_latch_pol: assert property (@(posedge clock) disable iff (!arst_n)
        !port_active |-> addr_latch_low == !ctrl_ff[`BIT_ALP]
        && addr_latch_high == !ctrl_ff[`BIT_ALP]) else $error("latch not inactive");
    a_latch_active: assert property (@(posedge clock) disable iff (!arst_n)
        port_active && xfer_latch_high |-> addr_latch_high == ctrl_ff[`BIT_ALP])
        else $error("latch not active");
    a_cs2_pol: assert property (@(posedge clock) disable iff (!arst_n)
        !port_active && chip_select_function == CSF_CS_BOTH |-> chip_select_two == !ctrl_ff[`BIT_SECOND_SELECT_POLARITY])
        else $error("select two not inactive");
    a_cs2_active: assert property (@(posedge clock) disable iff (!arst_n)
        port_active && chip_select_function == CSF_CS_BOTH && xfer_cs2 |-> chip_select_two == ctrl_ff[`BIT_SECOND_SELECT_POLARITY])
        else $error("select two not active");
    // Holding the select function steady keeps the address source fixed across the check.
    a_cs1_noeffect: assert property (@(posedge clock) disable iff (!arst_n)
        chip_select_function == CSF_CS2_ONLY && $stable(chip_select_function) && $changed(ctrl_ff[`BIT_CS1P])
        && $stable(xfer_addr) |-> $stable(chip_select_one))
        else $error("polarity moved address");
    // A stopped port leaves every strobe, and each select that is not an address line, at its inactive level.
    a_off_strobes: assert property (@(posedge clock) disable iff (!arst_n)
        !port_active |-> write_strobe_out == !ctrl_ff[`BIT_WRSP]
        && read_strobe_out == !ctrl_ff[`BIT_RDSP]) else $error("strobe active off");
    a_off_byte: assert property (@(posedge clock) disable iff (!arst_n)
        !port_active |-> byte_enable_out == !ctrl_ff[`BIT_BEP])
        else $error("byte enable active off");
    a_off_select: assert property (@(posedge clock) disable iff (!arst_n)
        !port_active && chip_select_function == CSF_CS_BOTH |-> chip_select_one == !ctrl_ff[`BIT_CS1P])
        else $error("select one not inactive");

    // Covers for the main scenarios.
    c_grant: cover property (@(posedge clock) disable iff (!arst_n) xfer_grant);
    c_idle_halt: cover property (@(posedge clock) disable iff (!arst_n)
        ctrl_ff[`BIT_PORT_EN] && idle_mode && !port_active);
    c_cs_both: cover property (@(posedge clock) disable iff (!arst_n)
        chip_select_function == CSF_CS_BOTH && port_active);
    c_low_byte: cover property (@(posedge clock) disable iff (!arst_n)
        addr_data_mux_select == 2'b01 && xfer_grant);
    c_cs_single: cover property (@(posedge clock) disable iff (!arst_n)
        chip_select_function == CSF_CS2_ONLY && $changed(ctrl_ff[`BIT_CS1P]));
endmodule

// ==== testbench/pmp_far_device.sv ====
// Behavioural far-side peripheral that counts the write strobes it is handed.
`timescale 1ns/1ps
module pmp_far_device (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        write_strobe_oe,
    input  wire logic        write_strobe_out,
    input  wire logic        active_high,
    output logic      [15:0] writes_ff
);
    logic [15:0] nxt_writes;
    // A strobe counts only while the pin is driven; a released pin means nothing to us.
    always_comb begin
        nxt_writes = writes_ff;
        if (write_strobe_oe && (write_strobe_out == active_high)) begin
            nxt_writes = writes_ff + 16'h0001;
        end
    end
    // Count register.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            writes_ff <= 16'h0000;
        end else begin
            writes_ff <= nxt_writes;
        end
    end
endmodule

// ==== testbench/parallel_master_port_control_bench.sv ====
// Random and corner-case bench of the parallel port control block.
`timescale 1ns/1ps
module parallel_master_port_control_bench;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        idle_mode = 1'b0;
    logic        xfer_req = 1'b0;
    logic [6:0]  strb = 7'h00;
    logic [15:0] xfer_addr = 16'h0000;
    logic [15:0] ctrl = 16'h0000;
    logic [15:0] reg_rdata;
    logic [15:0] writes;
    logic [15:0] base;
    logic [15:0] exp_writes;
    wire  [15:0] seen;
    int          miscompares = 0;
    int          tests_run = 0;
    int          cycles = 0;
    // Strobe order in strb: cs1, cs2, latch low, latch high, write, read, byte enable.
    parallel_master_port_control u_parallel_master_port_control (
        .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode),
        .xfer_cs1(strb[6]), .xfer_cs2(strb[5]), .xfer_latch_low(strb[4]),
        .xfer_latch_high(strb[3]), .xfer_wr(strb[2]), .xfer_rd(strb[1]), .xfer_be(strb[0]),
        .xfer_req(xfer_req), .xfer_addr(xfer_addr), .port_active(seen[15]),
        .xfer_grant(seen[14]), .addr_data_mux_select(seen[13:12]),
        .upper_addr_pins_en(seen[11]), .chip_select_one(seen[10]),
        .chip_select_two(seen[9]), .addr_latch_low(seen[8]), .addr_latch_high(seen[7]),
        .write_strobe_out(seen[6]), .write_strobe_oe(seen[5]), .read_strobe_out(seen[4]),
        .read_strobe_oe(seen[3]), .byte_enable_out(seen[2]), .byte_enable_oe(seen[1]));
    assign seen[0] = 1'b0;
    pmp_far_device u_pmp_far_device (
        .clock(clock), .arst_n(arst_n), .write_strobe_oe(seen[5]),
        .write_strobe_out(seen[6]), .active_high(ctrl[1]), .writes_ff(writes));
    // Clock at 200 MHz.
    always #2.5 clock = ~clock;
    // A pin level is the gated strobe XNOR its polarity, so idle pins sit at the inverse.
    function automatic logic [15:0] expect_pins(input logic [15:0] c, input logic idle,
                                                input logic req, input logic [6:0] s,
                                                input logic [15:0] a);
        logic       act;
        logic [6:0] g;
        act = c[15] & ~(c[13] & idle);
        g = s & {7{act}};
        return {act, req & act, c[12:11], c[12:11] != 2'b10,
                (c[7:6] == 2'b00) ? a[15] : (c[7:6] == 2'b01) ? a[14] : g[6] ~^ c[3],
                (c[7:6] == 2'b00) ? a[14] : g[5] ~^ c[4], g[4] ~^ c[5], g[3] ~^ c[5],
                g[2] ~^ c[1], c[9], g[1] ~^ c[0], c[8], g[0] ~^ c[2], c[10], 1'b0};
    endfunction
    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_pins();
        check_word("pins", expect_pins(ctrl, idle_mode, xfer_req, strb, xfer_addr), seen);
    endtask
    task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, then fall to zero.
    task automatic read_reg(input logic [3:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 check_word("rdata", exp, reg_rdata);
        @(posedge clock);
        #1 check_word("rdata_after", 16'h0000, reg_rdata);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // A hang is cut short well beyond the expected run length.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(56));
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        #1 check_pins();
        read_reg(4'h0, 16'h0000);
        write_reg(4'h5, 16'hFFFF);
        read_reg(4'h5, 16'h0000);
        read_reg(4'h0, 16'h0000);
        for (int i = 0; i < 200; i++) begin
            ctrl = 16'($urandom);
            if (ctrl[12:11] == 2'b11) ctrl[12] = 1'b0;
            if (ctrl[7:6] == 2'b11) ctrl[7] = 1'b0;
            write_reg(4'h0, ctrl);
            ctrl = ctrl & 16'hBFFF;
            for (int j = 0; j < 4; j++) begin
                idle_mode <= 1'($urandom);
                xfer_req <= 1'($urandom);
                strb <= 7'($urandom);
                xfer_addr <= 16'($urandom);
                #1 check_pins();
                @(posedge clock);
            end
            read_reg(4'h0, ctrl);
            read_reg(4'h1, {15'h0000, ctrl[15] & ~(ctrl[13] & idle_mode)});
        end
        // Write strobe held active: none reach the far side while disabled or released.
        for (int en = 0; en < 3; en++) begin
            ctrl = (en == 2) ? 16'h8002 : (16'h0202 | 16'(en << 15));
            exp_writes = (en == 1) ? 16'h0004 : 16'h0000;
            write_reg(4'h0, ctrl);
            idle_mode <= 1'b0;
            strb <= 7'h04;
            #1 base = writes;
            repeat (4) @(posedge clock);
            #1 check_word("far_writes", base + exp_writes, writes);
        end
        // A reset in mid-run returns the control word to zero and quiets every pin but the two selects, which carry address bits.
        arst_n <= 1'b0;
        ctrl = 16'h0000;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        #1 check_pins();
        read_reg(4'h0, 16'h0000);
        // Polarity flips on an address-line select pin leave it on its address bit.
        ctrl = 16'h8040;
        write_reg(4'h0, ctrl);
        #1 check_pins();
        ctrl = 16'h8048;
        write_reg(4'h0, ctrl);
        #1 check_pins();
        repeat (2) @(posedge clock);
        give_verdict();
    end
endmodule
